//--- rtl/pcm_top.sv
// Contract
// - in I2C mode the serial port data output overrides the latch on pin 4
// - I2C pin input buffer type follows the serial port's own setting
// - segment 16 or 12 enabled owns pin 4 or 5 exclusively
// - segment 27 or 28 enabled owns pin 6 or 7 exclusively
// - synchronous serial module output overrides latch on pins 6 and 7
// - synchronous slave with direction 1 takes its clock from pin 6
// - direction 1 on pin 7 feeds asynchronous receive through Schmitt input
// - pin 5 carries SPI data output when its direction bit is 0
// - pin 4 feeds SPI data input through Schmitt buffer
// - peripheral owned pins ignore the port direction bit
// - small variant: segment enables 33 to 39 absent, read zero
// - channel two routes to its default pin when select bit set
// - reset leaves every pin that no enabled serial peripheral owns (pin 4, 6 or 7) as a digital input
// - direction register reads back stored value despite overrides
// - plain port I/O only while the pin's segment is disabled
`timescale 1ns/1ps
`include "pcm_params.svh"

module pcm_top #(
    parameter bit SMALL_PIN_COUNT = 1'b0
) (
    input  wire logic                    clock,
    input  wire logic                    srst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`PCM_AW-1:0]      paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [`PCM_UPPER_W-1:0] pin_in,
    output logic      [`PCM_UPPER_W-1:0] pin_out,
    output logic      [`PCM_UPPER_W-1:0] pin_oe_n,
    output logic      [`PCM_UPPER_W-1:0] pin_analog_sel,
    input  wire logic                    ssp_enable,
    input  wire logic                    ssp_i2c_mode,
    input  wire logic                    ssp_i2c_levels,
    input  wire logic                    i2c_data_out,
    input  wire logic                    spi_data_out,
    output logic                         spi_data_in,
    output logic                         i2c_data_in,
    output logic                         pin4_i2c_buffer,
    input  wire logic                    usart_enable,
    input  wire logic                    usart_sync,
    input  wire logic                    usart_master,
    input  wire logic                    usart_tx_out,
    input  wire logic                    usart_dt_out,
    input  wire logic                    usart_dt_oe,
    output logic                         usart_clock_in,
    output logic                         usart_rx_in,
    output logic                         usart_dt_in,
    input  wire logic                    lcd_lcd_segment_sixteen_drive,
    input  wire logic                    lcd_lcd_segment_twelve_drive,
    input  wire logic                    lcd_lcd_segment_twenty_seven_drive,
    input  wire logic                    lcd_lcd_segment_twenty_eight_drive,
    input  wire logic                    ccp_two_pin_select,
    output logic                         ccp2_on_default_pin
);
    pcm_pkg::pcm_regs_t         st_reg;
    pcm_pkg::pcm_regs_t         st_next;
    logic [`PCM_UPPER_W-1:0]    lvl;
    logic [`PCM_UPPER_W-1:0]    seg_on;
    logic [`PCM_UPPER_W-1:0]    own;
    logic [`PCM_UPPER_W-1:0]    pdata;
    logic [`PCM_UPPER_W-1:0]    pod;
    logic [`PCM_UPPER_W-1:0]    pdrive;
    logic [`PCM_UPPER_W-1:0]    seg_lvl;
    logic [7:0]                 pin_rd;
    logic                       setup_ph;
    logic                       write_ph;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // segment n lives in register (n-8)/8, bit (n-8)%8
    function automatic logic seg_bit(input logic [3:0][7:0] se, input logic [7:0] n);
        logic [7:0] off;
        off = n - `PCM_SEG_BASE;
        return se[off[4:3]][off[2:0]];
    endfunction : seg_bit

    function automatic logic addr_hit(input logic [`PCM_AW-1:0] a);
        return (a == `PCM_OFF_PIN_LEVEL) || (a == `PCM_OFF_LATCH) || (a == `PCM_OFF_DIR)
            || (a == `PCM_OFF_SE_8) || (a == `PCM_OFF_SE_16) || (a == `PCM_OFF_SE_24)
            || (a == `PCM_OFF_SE_32) || (a == `PCM_OFF_OPEN_DRAIN);
    endfunction : addr_hit

    function automatic logic [7:0] read_byte(input logic [`PCM_AW-1:0] a,
                                             input pcm_pkg::pcm_regs_t s,
                                             input logic [7:0] pins);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `PCM_OFF_PIN_LEVEL:  v = pins;
            `PCM_OFF_LATCH:      v = s.latch_reg;
            `PCM_OFF_DIR:        v = s.dir_reg;
            `PCM_OFF_SE_8:       v = s.se_reg[0];
            `PCM_OFF_SE_16:      v = s.se_reg[1];
            `PCM_OFF_SE_24:      v = s.se_reg[2];
            `PCM_OFF_SE_32:      v = s.se_reg[3];
            `PCM_OFF_OPEN_DRAIN: v = s.od_reg;
            default:             v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    pcm_pin_sync u_sync (
        .clock   (clock),
        .srst    (srst),
        .pin_raw (pin_in),
        .level   (lvl)
    );

    // ------------------------------------------------------------
    // function ownership per pin
    // ------------------------------------------------------------
    always_comb
    begin
        seg_on[`PCM_P4]  = seg_bit(st_reg.se_reg, `PCM_SEG_P4);
        seg_on[`PCM_P5]  = seg_bit(st_reg.se_reg, `PCM_SEG_P5);
        seg_on[`PCM_P6]  = seg_bit(st_reg.se_reg, `PCM_SEG_P6);
        seg_on[`PCM_P7]  = seg_bit(st_reg.se_reg, `PCM_SEG_P7);
        seg_lvl[`PCM_P4] = lcd_lcd_segment_sixteen_drive;
        seg_lvl[`PCM_P5] = lcd_lcd_segment_twelve_drive;
        seg_lvl[`PCM_P6] = lcd_lcd_segment_twenty_seven_drive;
        seg_lvl[`PCM_P7] = lcd_lcd_segment_twenty_eight_drive;
        // pin 4: I2C data is open drain and beats the latch
        own[`PCM_P4]     = ssp_enable & ssp_i2c_mode;
        pdata[`PCM_P4]   = i2c_data_out;
        pod[`PCM_P4]     = 1'b1;
        pdrive[`PCM_P4]  = 1'b1;
        // pin 5: SPI data out only while direction is output
        own[`PCM_P5]     = ssp_enable & ~ssp_i2c_mode
                         & ~st_reg.dir_reg[`PCM_P5 + `PCM_UPPER_W];
        pdata[`PCM_P5]   = spi_data_out;
        pod[`PCM_P5]     = st_reg.od_reg[`PCM_OD_SPI_ONE];
        pdrive[`PCM_P5]  = 1'b1;
        // pin 6: transmit, or clock as sync master; sync slave leaves it to the port
        own[`PCM_P6]     = usart_enable & (~usart_sync | usart_master);
        pdata[`PCM_P6]   = usart_tx_out;
        pod[`PCM_P6]     = 1'b0;
        pdrive[`PCM_P6]  = 1'b1;
        // pin 7: sync data out while the serial module drives it
        own[`PCM_P7]     = usart_enable & usart_sync & usart_dt_oe;
        pdata[`PCM_P7]   = usart_dt_out;
        pod[`PCM_P7]     = 1'b0;
        pdrive[`PCM_P7]  = 1'b1;
    end

    // ------------------------------------------------------------
    // pad routing, one instance per upper pin
    // ------------------------------------------------------------
    for (genvar i = 0; i < `PCM_UPPER_W; i++)
    begin : g_pin
        pcm_pin_if pif ();
        assign pif.seg_en    = seg_on[i];
        assign pif.seg_level = seg_lvl[i];
        assign pif.per_own   = own[i];
        assign pif.per_drive = pdrive[i];
        assign pif.per_data  = pdata[i];
        assign pif.per_od    = pod[i];
        assign pif.latch     = st_reg.latch_reg[i + `PCM_UPPER_W];
        assign pif.dir       = st_reg.dir_reg[i + `PCM_UPPER_W];
        assign pin_out[i]        = pif.pad_out;
        assign pin_oe_n[i]       = pif.pad_oe_n;
        assign pin_analog_sel[i] = pif.seg_sel;
        pcm_pin_route u_route (
            .pin (pif)
        );
    end

    // ------------------------------------------------------------
    // peripheral inputs; a segment-owned pin feeds nothing digital
    // ------------------------------------------------------------
    always_comb
    begin
        spi_data_in     = lvl[`PCM_P4] & ~seg_on[`PCM_P4];
        i2c_data_in     = ~seg_on[`PCM_P4] & (~ssp_i2c_mode | lvl[`PCM_P4]);
        pin4_i2c_buffer = ssp_i2c_mode & ssp_i2c_levels;
        usart_clock_in  = usart_sync & ~usart_master & ~seg_on[`PCM_P6]
                        & st_reg.dir_reg[`PCM_P6 + `PCM_UPPER_W] & lvl[`PCM_P6];
        // idle high keeps the receiver from seeing a false start bit
        usart_rx_in     = ~(st_reg.dir_reg[`PCM_P7 + `PCM_UPPER_W] & ~seg_on[`PCM_P7])
                        | lvl[`PCM_P7];
        // sync receive relies on software having made pin 7 an input
        usart_dt_in     = st_reg.dir_reg[`PCM_P7 + `PCM_UPPER_W] & ~seg_on[`PCM_P7]
                        & lvl[`PCM_P7];
        pin_rd          = {lvl & ~seg_on, 4'h0};
        ccp2_on_default_pin = st_reg.ccp2_reg;
    end

    // ------------------------------------------------------------
    // apb slave: zero wait states, read data latched in setup
    // ------------------------------------------------------------
    assign setup_ph = psel & ~penable;
    assign write_ph = psel & penable & pwrite & pready;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_hit(paddr);
    assign prdata   = {24'h000000, st_reg.rdata_reg};

    always_comb
    begin
        st_next = st_reg;
        // strap is sampled once after reset, never under it
        if (!st_reg.strap_done_reg)
        begin
            st_next.ccp2_reg       = ccp_two_pin_select;
            st_next.strap_done_reg = 1'b1;
        end
        if (setup_ph)
            st_next.rdata_reg = read_byte(paddr, st_reg, pin_rd);
        if (write_ph)
        begin
            unique case (paddr)
                `PCM_OFF_PIN_LEVEL,
                `PCM_OFF_LATCH:      st_next.latch_reg = pwdata[7:0];
                `PCM_OFF_DIR:        st_next.dir_reg   = pwdata[7:0];
                `PCM_OFF_SE_8:       st_next.se_reg[0] = pwdata[7:0];
                `PCM_OFF_SE_16:      st_next.se_reg[1] = pwdata[7:0];
                `PCM_OFF_SE_24:      st_next.se_reg[2] = pwdata[7:0];
                // absent enables on the small part never store a one
                `PCM_OFF_SE_32:      st_next.se_reg[`PCM_SE_IDX_32] = pwdata[7:0]
                    & (SMALL_PIN_COUNT ? `PCM_SE32_SMALL_MASK : `PCM_FULL_MASK);
                `PCM_OFF_OPEN_DRAIN: st_next.od_reg = pwdata[7:0] & `PCM_OD_MASK;
                default:             st_next.rdata_reg = st_reg.rdata_reg;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_reg         <= '0;
            st_reg.latch_reg <= `PCM_RST_LATCH;
            st_reg.dir_reg <= `PCM_RST_DIR;
        end
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_i2c_data_drive: assert property (
        own[`PCM_P4] && !seg_on[`PCM_P4] |-> pin_out[`PCM_P4] == i2c_data_out
            && pin_oe_n[`PCM_P4] == i2c_data_out)
        else $error("pin 4 not following i2c data");
    chk_seg_low_pins: assert property (
        seg_on[`PCM_P5] |-> pin_out[`PCM_P5] == lcd_lcd_segment_twelve_drive && !pin_oe_n[`PCM_P5]
            && pin_analog_sel[`PCM_P5])
        else $error("segment 12 not owning pin 5");
    chk_seg_high_pins: assert property (
        seg_on[`PCM_P7] |-> pin_out[`PCM_P7] == lcd_lcd_segment_twenty_eight_drive && !usart_dt_in)
        else $error("segment 28 not owning pin 7");
    chk_sync_data_drive: assert property (
        usart_enable && usart_sync && usart_dt_oe && !seg_on[`PCM_P7]
            |-> pin_out[`PCM_P7] == usart_dt_out && !pin_oe_n[`PCM_P7])
        else $error("pin 7 not driven by sync data");
    chk_spi_in_path: assert property (
        (pin_in[`PCM_P4] && !seg_on[`PCM_P4])[*5] |-> spi_data_in)
        else $error("spi input not reaching after sampling");
    chk_dir_readback: assert property (
        setup_ph && paddr == `PCM_OFF_DIR ##1 penable |-> prdata[7:0] == $past(st_reg.dir_reg))
        else $error("direction readback mismatch");
    chk_reset_inputs: assert property (
        $past(srst) |-> pin_oe_n == 4'hF)
        else $error("pin driven right after reset");
    chk_small_variant: assert property (
        SMALL_PIN_COUNT |-> st_reg.se_reg[`PCM_SE_IDX_32][7:1] == 7'h00)
        else $error("absent segment enable holds a one");
    chk_port_drive: assert property (
        !own[`PCM_P6] && !seg_on[`PCM_P6] && !st_reg.dir_reg[`PCM_P6 + `PCM_UPPER_W]
            |-> pin_out[`PCM_P6] == st_reg.latch_reg[`PCM_P6 + `PCM_UPPER_W]
            && !pin_oe_n[`PCM_P6])
        else $error("pin 6 not driving latch");
    chk_slave_clock_in: assert property (
        usart_sync && !usart_master && !seg_on[`PCM_P6]
            && st_reg.dir_reg[`PCM_P6 + `PCM_UPPER_W] |-> usart_clock_in == lvl[`PCM_P6]
            && pin_oe_n[`PCM_P6])
        else $error("slave clock not taken from pin 6");
endmodule : pcm_top

//--- shared/pcm_params.svh
`ifndef PCM_PARAMS_SVH
`define PCM_PARAMS_SVH

// ------------------------------------------------------------
// bus and register map
// ------------------------------------------------------------
`define PCM_AW              12
`define PCM_OFF_PIN_LEVEL   12'h000
`define PCM_OFF_LATCH       12'h004
`define PCM_OFF_DIR         12'h008
`define PCM_OFF_SE_8        12'h00C
`define PCM_OFF_SE_16       12'h010
`define PCM_OFF_SE_24       12'h014
`define PCM_OFF_SE_32       12'h018
`define PCM_OFF_OPEN_DRAIN  12'h01C

// ------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------
`define PCM_RST_LATCH       8'h00
`define PCM_RST_DIR         8'hFF
`define PCM_OD_MASK         8'hE1
`define PCM_SE32_SMALL_MASK 8'h01
`define PCM_FULL_MASK       8'hFF

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCM_UPPER_W         4
`define PCM_P4              0
`define PCM_P5              1
`define PCM_P6              2
`define PCM_P7              3
`define PCM_OD_SPI_ONE      7
`define PCM_SE_IDX_32       3
`define PCM_SEG_BASE        8'h08
`define PCM_SEG_P4          8'h10
`define PCM_SEG_P5          8'h0C
`define PCM_SEG_P6          8'h1B
`define PCM_SEG_P7          8'h1C

`endif

//--- shared/pcm_pkg.sv
package pcm_pkg;

    // register state of the top module
    typedef struct packed {
        logic [7:0]      latch_reg;
        logic [7:0]      dir_reg;
        logic [3:0][7:0] se_reg;
        logic [7:0]      od_reg;
        logic            ccp2_reg;
        logic            strap_done_reg;
        logic [7:0]      rdata_reg;
    } pcm_regs_t;

    // three-stage pin sampler state
    typedef struct packed {
        logic [3:0] s1_reg;
        logic [3:0] s2_reg;
        logic [3:0] s3_reg;
        logic [3:0] level_reg;
    } pcm_sync_t;

endpackage : pcm_pkg

//--- shared/pcm_pin_if.sv
`timescale 1ns/1ps

// one pad's selection request and resulting drive
interface pcm_pin_if;
    logic seg_en;
    logic seg_level;
    logic per_own;
    logic per_drive;
    logic per_data;
    logic per_od;
    logic latch;
    logic dir;
    logic pad_out;
    logic pad_oe_n;
    logic seg_sel;

    modport ctrl  (output seg_en, seg_level, per_own, per_drive, per_data, per_od, latch, dir,
                   input  pad_out, pad_oe_n, seg_sel);
    modport route (input  seg_en, seg_level, per_own, per_drive, per_data, per_od, latch, dir,
                   output pad_out, pad_oe_n, seg_sel);
endinterface : pcm_pin_if

//--- rtl/pcm_pin_sync.sv
`timescale 1ns/1ps
`include "pcm_params.svh"

module pcm_pin_sync (
    input  wire logic                    clock,
    input  wire logic                    srst,
    input  wire logic [`PCM_UPPER_W-1:0] pin_raw,
    output logic      [`PCM_UPPER_W-1:0] level
);
    pcm_pkg::pcm_sync_t st_reg;
    pcm_pkg::pcm_sync_t st_next;

    // ------------------------------------------------------------
    // three sampling flops and a level flop; a level counts only once stages two and three agree
    // ------------------------------------------------------------
    always_comb
    begin
        st_next        = st_reg;
        st_next.s1_reg = pin_raw;
        st_next.s2_reg = st_reg.s1_reg;
        st_next.s3_reg = st_reg.s2_reg;
        // stage one is never looked at here: it may be metastable
        st_next.level_reg = (st_reg.s2_reg & ~(st_reg.s2_reg ^ st_reg.s3_reg))
                          | (st_reg.level_reg & (st_reg.s2_reg ^ st_reg.s3_reg));
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign level = st_reg.level_reg;
endmodule : pcm_pin_sync

//--- rtl/pcm_pin_route.sv
`timescale 1ns/1ps

module pcm_pin_route (
    pcm_pin_if.route pin
);
    // ------------------------------------------------------------
    // segment first, then peripheral, then plain port
    // ------------------------------------------------------------
    always_comb
    begin
        pin.seg_sel  = 1'b0;
        pin.pad_out  = pin.latch;
        pin.pad_oe_n = pin.dir;
        if (pin.seg_en)
        begin
            // segment drive shuts out every digital function
            pin.seg_sel  = 1'b1;
            pin.pad_out  = pin.seg_level;
            pin.pad_oe_n = 1'b0;
        end
        else if (pin.per_own)
        begin
            // direction bit has no say while a peripheral owns the pin
            pin.pad_out  = pin.per_data;
            pin.pad_oe_n = ~pin.per_drive | (pin.per_od & pin.per_data);
        end
    end
endmodule : pcm_pin_route

//--- test/pcm_top_test.sv
`timescale 1ns/1ps
`include "pcm_params.svh"

module pcm_top_test;
    logic                clock, srst, psel, penable, pwrite, pready, pslverr;
    logic [`PCM_AW-1:0]  paddr;
    logic [31:0]         pwdata, prdata;
    logic [3:0]          pin_in, pin_out, pin_oe_n, pin_analog_sel, seg_drv;
    logic                ssp_enable, ssp_i2c_mode, ssp_i2c_levels, i2c_data_out;
    logic                spi_data_out, spi_data_in, i2c_data_in, pin4_i2c_buffer;
    logic                usart_enable, usart_sync, usart_master, usart_tx_out;
    logic                usart_dt_out, usart_dt_oe, usart_clock_in, usart_rx_in;
    logic                usart_dt_in, ccp_two_pin_select, ccp2_on_default_pin;
    logic [32:0]         exp_q[$];
    logic [32:0]         note;
    logic [7:0]          v;
    int                  miscompares = 0;
    int                  total_checks = 0;
    // segment enable register and bit owning pins 4 to 7
    localparam logic [`PCM_AW-1:0] SA [4] = '{`PCM_OFF_SE_16, `PCM_OFF_SE_8,
                                               `PCM_OFF_SE_24, `PCM_OFF_SE_24};
    localparam int SB [4] = '{0, 4, 3, 4};

    // small variant so the absent segment bits can be seen reading zero
    pcm_top #(.SMALL_PIN_COUNT(1'b1)) uut (
        .clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_in, .pin_out, .pin_oe_n, .pin_analog_sel, .ssp_enable,
        .ssp_i2c_mode, .ssp_i2c_levels, .i2c_data_out, .spi_data_out, .spi_data_in,
        .i2c_data_in, .pin4_i2c_buffer, .usart_enable, .usart_sync, .usart_master,
        .usart_tx_out, .usart_dt_out, .usart_dt_oe, .usart_clock_in, .usart_rx_in,
        .usart_dt_in, .lcd_lcd_segment_sixteen_drive(seg_drv[0]), .lcd_lcd_segment_twelve_drive(seg_drv[1]),
        .lcd_lcd_segment_twenty_seven_drive(seg_drv[2]), .lcd_lcd_segment_twenty_eight_drive(seg_drv[3]),
        .ccp_two_pin_select, .ccp2_on_default_pin
    );

    // -------------------------------------------------------------
    // reporting
    // -------------------------------------------------------------
    task automatic report(input string m);
        miscompares++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask : report

    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
        total_checks++;
        if (got !== exp)
            report(m);
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // -------------------------------------------------------------
    // apb master: aligns itself to a rising edge, so calls never collide
    // -------------------------------------------------------------
    task automatic apb(input logic wr, input logic [`PCM_AW-1:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        @(posedge clock);
        if (!wr)
            exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        for (int n = 0; n < 16; n++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
            if (n == 15)
                report("no pready");
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [`PCM_AW-1:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h000000000);
    endtask : wr

    task automatic rd(input logic [`PCM_AW-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, {25'h0000000, e});
    endtask : rd

    task automatic settle;
        @(negedge clock);
    endtask : settle

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask : done

    // -------------------------------------------------------------
    // read monitor: oldest note against each completed read
    // -------------------------------------------------------------
    always @(posedge clock)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            note = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1FFFFFFFF;
            total_checks++;
            if ({pslverr, prdata} !== note)
                report("read data or error flag");
        end
    end

    // clock and watchdog; the run needs well under a thousand cycles
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        #100000;
        report("watchdog expired");
        print_verdict();
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        {srst, ccp_two_pin_select} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata, pin_in, seg_drv} = '0;
        {ssp_enable, ssp_i2c_mode, ssp_i2c_levels, i2c_data_out, spi_data_out} = '0;
        {usart_enable, usart_sync, usart_master, usart_tx_out} = '0;
        {usart_dt_out, usart_dt_oe} = '0;
        void'($urandom(2));
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        rd(`PCM_OFF_LATCH, `PCM_RST_LATCH);
        rd(`PCM_OFF_DIR, `PCM_RST_DIR);
        rd(`PCM_OFF_SE_16, 8'h00);
        rd(`PCM_OFF_OPEN_DRAIN, 8'h00);
        apb(1'b0, 12'hFFC, 8'h00, {1'b1, 32'h00000000});
        settle();
        chk(pin_oe_n, 4'hF, "pins not inputs after reset");
        chk(4'(ccp2_on_default_pin), 4'h1, "strap not captured");
        done("reset");
        v = 8'($urandom);
        wr(`PCM_OFF_DIR, 8'h0F);
        wr(`PCM_OFF_LATCH, v);
        rd(`PCM_OFF_DIR, 8'h0F);
        settle();
        chk(pin_oe_n, 4'h0, "port not driving");
        chk(pin_out, v[7:4], "latch not on pins");
        wr(`PCM_OFF_DIR, 8'hFF);
        v = 8'($urandom);
        pin_in <= v[3:0];
        repeat (5) @(posedge clock);
        rd(`PCM_OFF_PIN_LEVEL, {v[3:0], 4'h0});
        done("port");
        wr(`PCM_OFF_DIR, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            seg_drv <= 4'($urandom);
            wr(SA[i], 8'h01 << SB[i]);
            settle();
            chk(pin_analog_sel, 4'h1 << i, "segment owner");
            chk(4'(pin_out[i]), 4'(seg_drv[i]), "segment drive");
            wr(SA[i], 8'h00);
        end
        wr(`PCM_OFF_SE_32, 8'hFF);
        rd(`PCM_OFF_SE_32, `PCM_SE32_SMALL_MASK);
        done("segments");
        wr(`PCM_OFF_DIR, 8'hFF);
        {ssp_enable, ssp_i2c_mode, ssp_i2c_levels} <= 3'b111;
        settle();
        chk({pin_oe_n[0], pin_out[0], pin4_i2c_buffer}, 4'h1, "i2c low");
        chk(4'(i2c_data_in), 4'(v[0]), "i2c data in");
        @(posedge clock);
        ssp_i2c_levels <= 1'b0;
        i2c_data_out <= 1'b1;
        settle();
        chk(4'(pin4_i2c_buffer), 4'h0, "i2c buffer select");
        chk(4'(pin_oe_n[0]), 4'h1, "i2c data not released");
        @(posedge clock);
        {ssp_i2c_mode, spi_data_out, pin_in} <= 6'b010001;
        wr(`PCM_OFF_DIR, 8'hDF);
        repeat (4) @(posedge clock);
        settle();
        chk({pin_out[1], pin_oe_n[1], spi_data_in}, 4'h5, "spi pins");
        // open-drain select: only the implemented bits store a one
        wr(`PCM_OFF_OPEN_DRAIN, 8'hFF);
        rd(`PCM_OFF_OPEN_DRAIN, `PCM_OD_MASK);
        settle();
        chk(4'(pin_oe_n[1]), 4'h1, "spi open drain not released");
        done("serial port");
        @(posedge clock);
        {ssp_enable, usart_enable, usart_sync, usart_master} <= 4'b0111;
        {usart_tx_out, usart_dt_out, usart_dt_oe} <= 3'b101;
        settle();
        chk({pin_out[3:2], pin_oe_n[3:2]}, 4'b0100, "sync master drive");
        @(posedge clock);
        {usart_master, usart_dt_oe, pin_in} <= 6'b000100;
        repeat (5) @(posedge clock);
        settle();
        chk({usart_clock_in, usart_dt_in, usart_rx_in, pin_oe_n[2]}, 4'h9, "slave in");
        // asynchronous mode: pin 6 transmits, pin 7 feeds the receiver
        @(posedge clock);
        {usart_sync, pin_in} <= 5'b01000;
        repeat (5) @(posedge clock);
        settle();
        chk({usart_rx_in, usart_clock_in, pin_oe_n[2], pin_out[2]}, 4'h9, "async");
        done("usart");
        @(posedge clock);
        {srst, ccp_two_pin_select, usart_enable, usart_sync} <= 4'b1000;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(`PCM_OFF_DIR, `PCM_RST_DIR);
        settle();
        chk({pin_oe_n[3:1], ccp2_on_default_pin}, 4'hE, "second reset");
        chk(pin_oe_n, 4'hF, "pin driven after second reset");
        done("second reset");
        print_verdict();
    end
endmodule : pcm_top_test
